// File: logic/tc_config_regs.sv
// Purpose: time-constant and digital configuration register bank
// Assumes: host register port already deserialised, synchronous to clock
// Notes: writes take effect one edge later; read data is registered
`timescale 1ns/1ps
module tc_config_regs (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            regHit,
  output logic      [1:0] tc_one_cap_code,
  output logic      [4:0] tc_one_res_code,
  output logic      [1:0] tc_two_cap_code,
  output logic      [5:0] tc_two_res_code,
  output logic      [3:0] sensor_lowest_freq_code,
  output logic      [2:0] conversion_period_code
);

  // sizes of the bank
  localparam int DATA_W   = 8;
  localparam int NUM_REGS = 3;
  localparam int IDX_W    = 2;

  typedef logic [DATA_W-1:0] byte_type;
  typedef logic [IDX_W-1:0]  index_type;

  // storage slots, in address order
  localparam index_type IDX_TC_ONE  = 2'h0;
  localparam index_type IDX_TC_TWO  = 2'h1;
  localparam index_type IDX_DIGITAL = 2'h2;

  // value of each slot after reset
  localparam byte_type RESET_TABLE [NUM_REGS] = '{
    tc_config_pkg::TC_ONE_RESET,
    tc_config_pkg::TC_TWO_RESET,
    tc_config_pkg::DIGITAL_CFG_RESET
  };

  // true for the three mapped offsets
  function automatic logic addr_is_mapped(
    input logic [7:0] addr
  );
    case (addr)
      tc_config_pkg::TC_ONE_OFFSET: begin
        addr_is_mapped = 1'b1;
      end
      tc_config_pkg::TC_TWO_OFFSET: begin
        addr_is_mapped = 1'b1;
      end
      tc_config_pkg::DIGITAL_CFG_OFFSET: begin
        addr_is_mapped = 1'b1;
      end
      default: begin
        addr_is_mapped = 1'b0;
      end
    endcase
  endfunction : addr_is_mapped

  // slot of a mapped offset; unmapped offsets fall on slot zero
  function automatic index_type addr_to_index(
    input logic [7:0] addr
  );
    case (addr)
      tc_config_pkg::TC_ONE_OFFSET: begin
        addr_to_index = IDX_TC_ONE;
      end
      tc_config_pkg::TC_TWO_OFFSET: begin
        addr_to_index = IDX_TC_TWO;
      end
      tc_config_pkg::DIGITAL_CFG_OFFSET: begin
        addr_to_index = IDX_DIGITAL;
      end
      default: begin
        addr_to_index = IDX_TC_ONE;
      end
    endcase
  endfunction : addr_to_index

  // capacitance code sits at the same place in both time-constant bytes
  function automatic logic [1:0] cap_field(
    input byte_type value
  );
    cap_field = value[tc_config_pkg::CAP_MSB:tc_config_pkg::CAP_LSB];
  endfunction : cap_field

  // selection and strobes
  wire [DATA_W-1:0] regFile [NUM_REGS];
  logic             addrMapped;
  index_type        addrIndex;
  logic             wrStrobe;
  logic             accessHit;
  byte_type         readSelect;
  byte_type         readValue;
  byte_type         nxt_regRdata;
  logic             nxt_regHit;
  byte_type         regRdata_ff;
  logic             regHit_ff;

  assign addrMapped = addr_is_mapped(regAddr);
  assign addrIndex  = addr_to_index(regAddr);

  // unmapped writes are dropped
  assign wrStrobe  = regWrite & addrMapped;
  assign accessHit = (regRead | regWrite) & addrMapped;

  // unmapped addresses read zero
  assign readSelect = regFile[addrIndex];
  assign readValue  = addrMapped ? readSelect : 8'h00;

  // read data holds between reads; a write in the same cycle is not yet seen
  assign nxt_regRdata = regRead ? readValue : regRdata_ff;
  assign nxt_regHit   = accessHit;

  // one byte of flip-flops per slot
  genvar slot;
  generate
    for (slot = 0; slot < NUM_REGS; slot++) begin : g_slot
      logic     slotWrite;
      byte_type cell_ff;

      assign slotWrite = wrStrobe & (addrIndex == index_type'(slot));

      // whole byte stored, reserved bits included
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          cell_ff <= RESET_TABLE[slot];
        end else if (slotWrite) begin
          cell_ff <= regWdata;
        end
      end

      assign regFile[slot] = cell_ff;
    end
  endgenerate

  // registered read port
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_ff <= 8'h00;
      regHit_ff   <= 1'b0;
    end else begin
      regRdata_ff <= nxt_regRdata;
      regHit_ff   <= nxt_regHit;
    end
  end

  assign regRdata = regRdata_ff;
  assign regHit   = regHit_ff;

  // field outputs straight from the storage flip-flops
  assign tc_one_cap_code =
    cap_field(regFile[IDX_TC_ONE]);
  assign tc_one_res_code =
    regFile[IDX_TC_ONE][tc_config_pkg::ONE_RES_MSB:0];
  assign tc_two_cap_code =
    cap_field(regFile[IDX_TC_TWO]);
  assign tc_two_res_code =
    regFile[IDX_TC_TWO][tc_config_pkg::TWO_RES_MSB:0];
  assign sensor_lowest_freq_code =
    regFile[IDX_DIGITAL][tc_config_pkg::FREQ_MSB:tc_config_pkg::FREQ_LSB];
  assign conversion_period_code =
    regFile[IDX_DIGITAL][tc_config_pkg::RESP_MSB:0];

  // reserved bits (bit 5 of slot zero, bit 3 of the digital slot) are
  // kept in the byte and only come back through the read port

  // the bank has no other state: every output above follows either the
  // storage bytes or the registered read port, so nothing is left over
  // from one access to the next beyond what the host has written

endmodule : tc_config_regs

// File: logic/tc_config_pkg.sv
// Purpose: constants for the time-constant and digital configuration register bank
// Assumes: 8-bit registers reached by a simple synchronous register port
// Notes: offsets are register addresses on the serial configuration port
// Summary of operation
// - first time-constant register at 0x02, reset 0x90, bit 5 reserved
// - first register bits 7:6: capacitance code 0.75/1.5/3/6 pF, resets 10
// - first register bits 4:0: resistance code, all values valid, resets 10000
// - second time-constant register at 0x03, reset 0xA0
// - second register bits 7:6: capacitance code 3/6/12/24 pF, resets 10
// - second register bits 5:0: resistance code, all values valid, resets 100000
// - digital configuration at 0x04, reset 0x03, frequency 7:4, response 2:0
package tc_config_pkg;
  localparam logic [7:0] TC_ONE_OFFSET  = 8'h02;
  localparam logic [7:0] TC_TWO_OFFSET  = 8'h03;
  localparam logic [7:0] DIGITAL_CFG_OFFSET = 8'h04;
  localparam logic [7:0] TC_ONE_RESET       = 8'h90;
  localparam logic [7:0] TC_TWO_RESET       = 8'hA0;
  localparam logic [7:0] DIGITAL_CFG_RESET  = 8'h03;
  localparam int CAP_MSB      = 7;
  localparam int CAP_LSB      = 6;
  localparam int ONE_RES_MSB  = 4;
  localparam int TWO_RES_MSB  = 5;
  localparam int FREQ_MSB     = 7;
  localparam int FREQ_LSB     = 4;
  localparam int RESP_MSB     = 2;
  localparam int ONE_RSVD_BIT = 5;
  localparam int DIG_RSVD_BIT = 3;
endpackage : tc_config_pkg

// File: sim/tc_config_regs_monitor.sv
// Purpose: port checker. Assumes: one clock. Notes: bound to tc_config_regs
`timescale 1ns/1ps
module tc_config_regs_monitor(input wire logic clock,arst_n,regWrite,regRead,regHit,
  input wire logic [7:0] regAddr,regWdata,regRdata,input wire logic [1:0] tc_one_cap_code,
  input wire logic [1:0] tc_two_cap_code,input wire logic [2:0] conversion_period_code);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire hit=regAddr inside {[8'h02:8'h04]};
  AST_HIT: assert property((regWrite|regRead)&&hit|=>regHit) else $error("no hit");
  AST_MISS: assert property(!((regWrite|regRead)&&hit)|=>!regHit) else $error("hit");
  AST_UNMAP: assert property(regRead&&!hit|=>regRdata==0) else $error("unmapped");
  AST_HOLD: assert property(!regRead|=>$stable(regRdata)) else $error("moved");
  AST_CAP: assert property(regWrite&&regAddr==2|=>tc_one_cap_code==$past(regWdata[7:6]))
    else $error("cap");
  AST_CAP_TWO: assert property(regWrite&&regAddr==8'h03|=>tc_two_cap_code==$past(regWdata[7:6]))
    else $error("cap two");
  AST_RESP: assert property(regWrite&&regAddr==8'h04|=>conversion_period_code==$past(regWdata[2:0]))
    else $error("resp");
  AST_KEEP: assert property(!regWrite|=>$stable(tc_one_cap_code)) else $error("kept");
  cover property(regWrite&&hit);
  cover property(regRead&&hit);
  cover property(regRead&&!hit);
endmodule : tc_config_regs_monitor
bind tc_config_regs tc_config_regs_monitor tc_config_regs_monitor_i(.*);

// File: sim/host_model.sv
// Purpose: host side. Assumes: falling-edge drive. Notes: one strobe a cycle
`timescale 1ns/1ps
module host_model(input wire logic clock,output logic regWrite=0,regRead=0,
  output logic [7:0] regAddr=0,regWdata=0);
  task acc(logic w,logic [7:0] a,d);
    @(negedge clock); regWrite=w; regRead=!w; regAddr=a; regWdata=d;
    @(negedge clock); regWrite=0; regRead=0;
  endtask : acc
endmodule : host_model

// File: sim/test_tc_config_regs.sv
// Purpose: bank bench. Assumes: host model. Notes: seed 89
`timescale 1ns/1ps
`define CHK(a,e) begin comparisons++; if((a)!==(e)) begin n_mismatch++; $display("MISMATCH %0t value differs",$time); end end
module test_tc_config_regs;
  logic clock=0,arst_n=0,regWrite,regRead,regHit,rd;
  logic [7:0] regAddr,regWdata,regRdata,d,m[8],q[$];
  logic hq[$];
  logic [1:0] tc_one_cap_code,tc_two_cap_code;
  logic [4:0] tc_one_res_code;
  logic [5:0] tc_two_res_code;
  logic [3:0] sensor_lowest_freq_code;
  logic [2:0] conversion_period_code;
  int n_mismatch=0,comparisons=0,seed=89,a;
  initial forever #4 clock=~clock;
  host_model host_model_i(.clock(clock),.regWrite(regWrite),.regRead(regRead),
    .regAddr(regAddr),.regWdata(regWdata));
  tc_config_regs tc_config_regs_i(.clock(clock),.arst_n(arst_n),.regAddr(regAddr),
    .regWrite(regWrite),.regRead(regRead),.regWdata(regWdata),.regRdata(regRdata),
    .regHit(regHit),.tc_one_cap_code(tc_one_cap_code),.tc_one_res_code(tc_one_res_code),
    .tc_two_cap_code(tc_two_cap_code),.tc_two_res_code(tc_two_res_code),
    .sensor_lowest_freq_code(sensor_lowest_freq_code),
    .conversion_period_code(conversion_period_code));
  always @(posedge clock) rd<=regRead;
  always @(negedge clock) if(rd) begin
    `CHK(regRdata,q.pop_front())
    `CHK(regHit,hq.pop_front())
  end
  task rdx(int a); q.push_back(m[a]); hq.push_back(a inside {[2:4]});
    host_model_i.acc(0,a,0); endtask : rdx
  task fields;
    `CHK(tc_one_cap_code,m[2][7:6])
    `CHK(tc_one_res_code,m[2][4:0])
    `CHK(tc_two_cap_code,m[3][7:6])
    `CHK(tc_two_res_code,m[3][5:0])
    `CHK(sensor_lowest_freq_code,m[4][7:4])
    `CHK(conversion_period_code,m[4][2:0])
  endtask : fields
  task run_reset; arst_n=0; repeat(12) @(negedge clock); arst_n=1;
    m='{0,0,8'h90,8'hA0,8'h03,0,0,0}; fields;
    for(a=0;a<6;a++) rdx(a);
    $display("reset test done"); endtask : run_reset
  task stop_test; $display("%0d bad of %0d",n_mismatch,comparisons);
    if(n_mismatch==0&&comparisons>0) $display("Regression OK"); else $display("Regression broken");
    $finish; endtask : stop_test
  // about 170 cycles expected; allow 1000
  initial begin #(1000*8); n_mismatch++; stop_test; end
  initial begin
    run_reset;
    repeat(30) begin a=1+{$random(seed)}%5; d=$random(seed); host_model_i.acc(1,a,d);
      if(a inside {[2:4]}) m[a]=d; fields; rdx(a); end
    $display("write test done");
    @(negedge clock); run_reset;
    repeat(3) @(negedge clock); $display("test done"); stop_test; end
endmodule : test_tc_config_regs
